//--- core/cat_consts.svh
// Purpose: constants of the counter array timebase
// Assumes: 100 MHz system clock
// Notes: widths fixed
`ifndef CAT_CONSTS_SVH
`define CAT_CONSTS_SVH
`define CAT_NUM_MOD      5
`define CAT_WD_MOD       4
`define CAT_DIV12        4'd12
`define CAT_DIV4         4'd4
`define CAT_DIV8         4'd8
`define CAT_WD_OFFSET    16'h0100
`define CAT_RST_SRC      3'h0
`endif

//--- core/cat_pkg.sv
// Purpose: types of the counter array timebase
// Assumes: none
// Notes: mode and clock source encodings
package cat_pkg;
	typedef enum logic [2:0] {
		CAT_SRC_DIV12 = 3'h0,
		CAT_SRC_DIV4  = 3'h1,
		CAT_SRC_T0OV  = 3'h2,
		CAT_SRC_ECI   = 3'h3,
		CAT_SRC_SYS   = 3'h4,
		CAT_SRC_XO8   = 3'h5
	} cat_src_t;
	typedef enum logic [2:0] {
		CAT_M_OFF   = 3'h0,
		CAT_M_CAPT  = 3'h1,
		CAT_M_SWT   = 3'h2,
		CAT_M_HSO   = 3'h3,
		CAT_M_PWM8  = 3'h4,
		CAT_M_PWM16 = 3'h5,
		CAT_M_FREQ  = 3'h6
	} cat_mode_t;
endpackage

//--- core/cat_counter_array.sv
// Purpose: 16-bit timebase with five capture/compare modules
// Assumes: pins arrive asynchronous, two-flop synchronised
// Notes: external oscillator rising edges counted, divided by 8
// Function
// [R1] one 16-bit timebase shared by five compare modules
// [R2] timebase clock picked from six sources
// [R3] external oscillator divided by 8 keeps counting independently
// [R4] each module runs exactly one selected mode
// [R5] pulse-width modulation in 8-bit and 16-bit variants
// [R6] module 4 can also serve as watchdog; the watchdog here is a separate wd_limit compare, not module 4
// [R7] watchdog armed and enabled after every reset
// [R8] module signals and count input go to the crossbar
// [R9] timebase adds one per tick and wraps to zero
`timescale 1ns/1ps
`include "cat_consts.svh"
module cat_counter_array (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic                                 run,
	input  wire logic [2:0]                           clk_src,
	input  wire logic                                 timer0_ovf,
	input  wire logic                                 external_count_input,
	input  wire logic                                 ext_osc,
	input  wire logic [`CAT_NUM_MOD*3-1:0]            mod_mode,
	input  wire logic [`CAT_NUM_MOD*16-1:0]           mod_cmp,
	input  wire logic [`CAT_NUM_MOD-1:0]              mod_pin_in,
	input  wire logic                                 wd_disable,
	input  wire logic                                 wd_kick,
	output logic      [15:0]                          count,
	output logic      [`CAT_NUM_MOD*16-1:0]           mod_capt,
	output logic      [`CAT_NUM_MOD-1:0]              mod_pin_out,
	output logic      [`CAT_NUM_MOD-1:0]              mod_event,
	output logic                                      eci_to_xbar,
	output logic                                      wd_enabled,
	output logic                                      wd_reset
);
	logic [1:0]             eci_s;
	logic [1:0]             xo_s;
	logic                   eci_d;
	logic                   xo_d;
	logic [3:0]             pre;
	logic [3:0]             xo_cnt;
	logic [`CAT_NUM_MOD-1:0] pin_s1;
	logic [`CAT_NUM_MOD-1:0] pin_s2;
	logic [`CAT_NUM_MOD-1:0] pin_d;
	logic [15:0]            wd_limit;
	wire                    eci_rise = eci_s[1] & ~eci_d;
	wire                    xo_rise  = xo_s[1] & ~xo_d;
	wire [3:0]              pre_lim  = (clk_src == 3'(cat_pkg::CAT_SRC_DIV12)) ?
		`CAT_DIV12 : `CAT_DIV4;
	wire                    pre_tick = (pre == pre_lim - 4'd1);
	wire                    xo_tick  = xo_rise && (xo_cnt == `CAT_DIV8 - 4'd1);
	logic                   tick;
	always_comb begin
		case (clk_src) // [R2]
		3'(cat_pkg::CAT_SRC_DIV12): tick = pre_tick;
		3'(cat_pkg::CAT_SRC_DIV4):  tick = pre_tick;
		3'(cat_pkg::CAT_SRC_T0OV):  tick = timer0_ovf;
		3'(cat_pkg::CAT_SRC_ECI):   tick = eci_rise;
		3'(cat_pkg::CAT_SRC_SYS):   tick = 1'b1;
		3'(cat_pkg::CAT_SRC_XO8):   tick = xo_tick; // [R3]
		default:                    tick = 1'b0;
		endcase
	end
	wire                    cnt_tick = run & tick;
	assign eci_to_xbar = eci_s[1]; // [R8]
	always_ff @(posedge clk) begin
		eci_s <= {eci_s[0], external_count_input};
		xo_s  <= {xo_s[0], ext_osc};
		eci_d <= eci_s[1];
		xo_d  <= xo_s[1];
		pin_s1 <= mod_pin_in;
		pin_s2 <= pin_s1;
		pin_d  <= pin_s2;
	end
	always_ff @(posedge clk) begin
		if (rst || pre_tick)
			pre <= 4'h0;
		else
			pre <= pre + 4'd1;
	end
	always_ff @(posedge clk) begin
		if (rst)
			xo_cnt <= 4'h0;
		else if (xo_rise) // [R3]
			xo_cnt <= (xo_cnt == `CAT_DIV8 - 4'd1) ? 4'h0 : xo_cnt + 4'd1;
	end
	always_ff @(posedge clk) begin
		if (rst)
			count <= 16'h0000;
		else if (cnt_tick)
			count <= count + 16'd1; // [R1] [R9]
	end
	function automatic logic cmp_hit(input logic [15:0] c, input logic [15:0] r,
		input logic b8);
		cmp_hit = b8 ? (c[7:0] == r[7:0]) : (c == r);
	endfunction
	genvar g;
	generate
		for (g = 0; g < `CAT_NUM_MOD; g++) begin : g_mod
			wire [2:0]  md  = mod_mode[g*3 +: 3];
			wire [15:0] ref_v = mod_cmp[g*16 +: 16];
			wire        is8 = (md == 3'(cat_pkg::CAT_M_PWM8));
			wire        hit = cnt_tick && cmp_hit(count, ref_v, is8);
			wire        edge_in = pin_s2[g] ^ pin_d[g];
			always_ff @(posedge clk) begin
				if (rst) begin
					mod_capt[g*16 +: 16] <= 16'h0000;
					mod_pin_out[g] <= 1'b0;
					mod_event[g] <= 1'b0;
				end else begin
					mod_event[g] <= 1'b0;
					case (md) // [R4]
					3'(cat_pkg::CAT_M_CAPT): if (edge_in) begin
						mod_capt[g*16 +: 16] <= count;
						mod_event[g] <= 1'b1;
					end
					3'(cat_pkg::CAT_M_SWT): mod_event[g] <= hit;
					3'(cat_pkg::CAT_M_HSO): if (hit) begin
						mod_pin_out[g] <= ~mod_pin_out[g];
						mod_event[g] <= 1'b1;
					end
					3'(cat_pkg::CAT_M_PWM8), 3'(cat_pkg::CAT_M_PWM16): begin // [R5]
						if (hit)
							mod_pin_out[g] <= 1'b1;
						else if (cnt_tick && (is8 ? count[7:0] == 8'hff : count == 16'hffff))
							mod_pin_out[g] <= 1'b0;
					end
					3'(cat_pkg::CAT_M_FREQ): if (cnt_tick && count[7:0] == 8'(ref_v[15:8] + ref_v[7:0]))
						mod_pin_out[g] <= ~mod_pin_out[g];
					default: mod_pin_out[g] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_enabled <= 1'b1; // [R7]
			wd_limit   <= `CAT_WD_OFFSET;
			wd_reset   <= 1'b0;
		end else begin
			if (wd_disable)
				wd_enabled <= 1'b0;
			if (wd_kick)
				wd_limit <= count + `CAT_WD_OFFSET;
			wd_reset <= wd_enabled && cnt_tick && (count == wd_limit); // [R6]
		end
	end
	AST_WD_ARMED: assert property (@(posedge clk) $fell(rst) |-> wd_enabled) // [R7]
		else $error("watchdog not armed after reset");
	AST_WRAP: assert property (@(posedge clk) disable iff (rst)
		cnt_tick && count == 16'hffff |=> count == 16'h0000) // [R9]
		else $error("timebase did not wrap");
	AST_INC: assert property (@(posedge clk) disable iff (rst)
		cnt_tick |=> count == $past(count) + 16'd1) // [R1]
		else $error("timebase did not increment");
	AST_HOLD: assert property (@(posedge clk) disable iff (rst)
		!cnt_tick |=> $stable(count)) // [R2]
		else $error("timebase moved without tick");
	AST_SYS: assert property (@(posedge clk) disable iff (rst)
		run && clk_src == 3'h4 |-> cnt_tick) // [R2]
		else $error("system clock source not ticking");
	AST_XO: assert property (@(posedge clk) disable iff (rst)
		xo_tick |-> xo_cnt == 4'd7) // [R3]
		else $error("external divide by 8 wrong");
	AST_WD_FIRE: assert property (@(posedge clk) disable iff (rst)
		wd_reset |-> $past(wd_enabled)) // [R6]
		else $error("watchdog fired while disabled");
	AST_ECI: assert property (@(posedge clk) disable iff (rst)
		$rose(eci_to_xbar) |=> !eci_rise ##0 $past(eci_rise)) // [R8]
		else $error("count input edge not seen");
	AST_PWM: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h4 && cnt_tick && count[7:0] == mod_cmp[7:0]
		##1 mod_mode[2:0] == 3'h4 |-> mod_pin_out[0]) // [R5]
		else $error("pwm output not set on match");
	AST_MODE: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h0 ##1 mod_mode[2:0] == 3'h0 |-> !mod_pin_out[0]) // [R4]
		else $error("idle module drives output");
	AST_CAPT: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h1 && (pin_s2[0] ^ pin_d[0]) |=> mod_event[0] && mod_capt[15:0] == $past(count)) // [R4]
		else $error("capture missed an input edge");
	AST_CAPT_HOLD: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h1 && !(pin_s2[0] ^ pin_d[0]) |=> $stable(mod_capt[15:0])) // [R4]
		else $error("capture register moved without edge");
	AST_SWT: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h2 && cnt_tick && count == mod_cmp[15:0] |=> mod_event[0]) // [R4]
		else $error("software timer match not flagged");
	AST_HSO: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h3 && cnt_tick && count == mod_cmp[15:0] |=> mod_pin_out[0] != $past(mod_pin_out[0])) // [R4]
		else $error("high speed output did not toggle");
	AST_PWM16: assert property (@(posedge clk) disable iff (rst)
		mod_mode[5:3] == 3'h5 && cnt_tick && count == mod_cmp[31:16] ##1 mod_mode[5:3] == 3'h5 |-> mod_pin_out[1]) // [R5]
		else $error("16-bit pwm output not set on match");
	AST_PWM_CLR: assert property (@(posedge clk) disable iff (rst)
		mod_mode[2:0] == 3'h4 && cnt_tick && count[7:0] == 8'hff && mod_cmp[7:0] != 8'hff |=> !mod_pin_out[0]) // [R5]
		else $error("8-bit pwm output not cleared at wrap");
	AST_FREQ: assert property (@(posedge clk) disable iff (rst)
		mod_mode[8:6] == 3'h6 && cnt_tick && count[7:0] == 8'(mod_cmp[47:40] + mod_cmp[39:32]) |=> $changed(mod_pin_out[2])) // [R4]
		else $error("frequency output did not toggle");
	AST_WD_KICK: assert property (@(posedge clk) disable iff (rst)
		wd_kick |=> wd_limit == $past(count) + `CAT_WD_OFFSET) // [R6]
		else $error("watchdog limit not reloaded");
	AST_WD_OFF: assert property (@(posedge clk) disable iff (rst)
		wd_disable |=> !wd_enabled) // [R6]
		else $error("watchdog not disabled");
	AST_WD_PULSE: assert property (@(posedge clk) disable iff (rst)
		wd_reset |=> !wd_reset) // [R6]
		else $error("watchdog expiry longer than one cycle");
	AST_RST_CNT: assert property (@(posedge clk)
		rst |=> count == 16'h0000 && mod_event == 5'h00 && !wd_reset) // [R7]
		else $error("reset did not clear timebase");
	AST_RUN_OFF: assert property (@(posedge clk) disable iff (rst)
		!run |-> !cnt_tick) // [R2]
		else $error("timebase ticked while stopped");
	AST_DIV12: assert property (@(posedge clk) disable iff (rst)
		clk_src == 3'h0 && pre_tick |-> pre == 4'd11) // [R2]
		else $error("divide by 12 prescaler wrong");
	AST_UNK_SRC: assert property (@(posedge clk) disable iff (rst)
		clk_src > 3'h5 |-> !tick) // [R2]
		else $error("unknown source produced a tick");
endmodule // cat_counter_array

//--- tb/cat_pin_model.sv
// Purpose: port pin side of the counter array, behind the crossbar
// Assumes: pins asynchronous to the system clock
// Notes: oscillator runs free, count input pulses on request
`timescale 1ns/1ps
module cat_pin_model (
	output logic       ext_osc,
	output logic       external_count_input,
	output logic [4:0] mod_pin_in
);
	// free-running oscillator, unrelated phase
	initial begin
		ext_osc = 1'b0;
		forever #23 ext_osc = ~ext_osc;
	end
	// module pins keep changing
	initial begin
		mod_pin_in = 5'h0a;
		forever #97 mod_pin_in = ~mod_pin_in;
	end
	initial external_count_input = 1'b0;
	// count input pulses, each held four system cycles
	task automatic eci_pulse(input int n);
		repeat (n) begin
			#40 external_count_input = 1'b1;
			#40 external_count_input = 1'b0;
		end
	endtask
endmodule // cat_pin_model

//--- tb/testbench.sv
// Purpose: self-checking bench of the counter array timebase
// Assumes: 100 MHz clock, inputs driven at falling edge
// Notes: results checked from a queue of expected event masks
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("Error %0t: got %0h exp %0h", $time, a, e); end end
module testbench;
	logic clk, rst, run, timer0_ovf, wd_disable, wd_kick, watch;
	logic [2:0] clk_src;
	logic [14:0] mod_mode;
	logic [79:0] mod_cmp;
	logic [15:0] count, a, r;
	logic [79:0] mod_capt;
	logic [4:0] mod_pin_in, mod_pin_out, mod_event, b, hi, lo;
	logic ext_osc, external_count_input, eci_to_xbar, wd_enabled, wd_reset;
	logic [5:0] exp_q[$];
	int fails = 0, n_checks = 0;
	cat_counter_array dut_u (.clk(clk), .rst(rst), .run(run), .clk_src(clk_src),
		.timer0_ovf(timer0_ovf), .external_count_input(external_count_input),
		.ext_osc(ext_osc), .mod_mode(mod_mode), .mod_cmp(mod_cmp), .mod_pin_in(mod_pin_in),
		.wd_disable(wd_disable), .wd_kick(wd_kick), .count(count), .mod_capt(mod_capt),
		.mod_pin_out(mod_pin_out), .mod_event(mod_event), .eci_to_xbar(eci_to_xbar),
		.wd_enabled(wd_enabled), .wd_reset(wd_reset));
	cat_pin_model pin_u (.ext_osc(ext_osc), .external_count_input(external_count_input),
		.mod_pin_in(mod_pin_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// result watcher
	always @(negedge clk) if (watch && {wd_reset, mod_event} !== 6'h00) begin
		if (exp_q.size() == 0) begin
			fails++;
			$display("Error %0t: unexpected event", $time);
		end else `CHK({wd_reset, mod_event}, exp_q.pop_front())
	end
	task automatic conclude;
		$display("checks %0d fails %0d", n_checks, fails);
		if (n_checks > 0 && fails == 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wait_q(input int lim);
		for (int i = 0; i < lim && exp_q.size() > 0; i++) @(negedge clk);
		`CHK(exp_q.size(), 0)
	endtask
	task automatic rate(input logic [2:0] s, input int cyc, input int n);
		logic [15:0] d;
		clk_src = s;
		a = count;
		repeat (cyc) @(negedge clk);
		d = count - a;
		`CHK(d + 16'd1 >= n && d <= n + 1, 1'b1)
		$display("rate test src %0d done", s);
	endtask
	initial begin
		#900_000 fails++;
		conclude();
	end
	initial begin
		{rst, run, clk_src, timer0_ovf, watch} = {2'b10, 3'h4, 2'b00};
		{mod_mode, mod_cmp, wd_disable, wd_kick} = '0;
		r = $urandom(32'h1e053c32);
		repeat (20) @(negedge clk);
		`CHK({count, wd_enabled}, 17'h00001)
		rst = 1'b0;
		run = 1'b1;
		watch = 1'b1;
		exp_q.push_back(6'h20);
		wd_kick = 1'b1;
		@(negedge clk);
		wd_kick = 1'b0;
		wait_q(400);
		{watch, wd_disable} = 2'b01;
		@(negedge clk);
		`CHK(wd_enabled, 1'b0)
		a = count;
		@(negedge clk);
		`CHK(count, a + 16'd1)
		run = 1'b0;
		rate(3'h4, 5, 0);
		run = 1'b1;
		rate(3'h0, 96, 8);
		rate(3'h1, 96, 24);
		rate(3'h4, 96, 96);
		rate(3'h6, 96, 0);
		rate(3'h5, 2000, 54);
		clk_src = 3'h2;
		a = count;
		repeat (7) begin
			timer0_ovf = 1'b1;
			@(negedge clk);
			timer0_ovf = 1'b0;
			repeat (2) @(negedge clk);
		end
		`CHK(count, a + 16'd7)
		clk_src = 3'h3;
		a = count;
		pin_u.eci_pulse(5);
		repeat (6) @(negedge clk);
		`CHK({count, eci_to_xbar}, {a + 16'd5, 1'b0})
		clk_src = 3'h4;
		a = count;
		repeat (65536) @(negedge clk);
		`CHK(count, a)
		run = 1'b0;
		r = count + 16'd5 + 16'($urandom % 200);
		mod_mode = {{3{3'h3}}, {2{3'h2}}};
		mod_cmp = {5{r}};
		@(negedge clk);
		b = mod_pin_out;
		exp_q.push_back(6'h1f);
		{watch, run} = 2'b11;
		wait_q(300);
		{watch, run} = 2'b00;
		`CHK(mod_pin_out, {~b[4:2], b[1:0]})
		mod_mode = {5{3'h1}};
		run = 1'b1;
		for (int i = 0; i < 30 && mod_event == 5'h00; i++) @(negedge clk);
		`CHK({mod_event, mod_capt}, {5'h1f, {5{count - 16'd1}}})
		mod_mode = {3'h4, 3'h4, 3'h6, 3'h5, 3'h4};
		mod_cmp = {5{8'h00, 8'h10 + 8'($urandom % 200)}};
		mod_cmp[31:16] = count + 16'd20;
		{run, hi, lo} = {1'b1, 10'h000};
		repeat (600) @(negedge clk) {hi, lo} = {hi | mod_pin_out, lo | ~mod_pin_out};
		`CHK({hi[2], lo[2], hi[0], lo[0], mod_pin_out[1]}, 5'h1f)
		$display("module tests done");
		conclude();
	end
endmodule // testbench
